// File: src/dmwe_pkg.sv
// Register map, field layout and codes of the display-mode and window-effects bank
package dmwe_pkg;
  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_DISP_MODE = 8'h34;
  localparam logic [7:0] OFS_WIN_FX = 8'h36;
  localparam logic [7:0] OFS_STATUS = 8'h50;
  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] RST_DISP_MODE = 8'h08;
  localparam logic [7:0] RST_WIN_FX = 8'h00;
  // ********************************
  // Field positions
  // ********************************
  localparam int BIT_BLANK = 7;
  localparam int SHADE_LSB = 4;
  localparam int BIT_RSV = 3;
  localparam int ROT_LSB = 0;
  localparam int BIT_DTYPE = 7;
  localparam int BIT_DBEN = 6;
  localparam int SIZE_LSB = 0;
  // Status bits
  localparam int ST_DBWIN = 0;
  localparam int ST_DBL = 1;
  localparam int ST_DBUF = 2;
  // ********************************
  // Codes
  // ********************************
  localparam logic [2:0] SHADE_BYPASS = 3'h0;
  localparam logic [2:0] SHADE_TEMPORAL = 3'h1;
  localparam logic [2:0] SHADE_DITHER = 3'h4;
  localparam logic [2:0] SHADE_BOTH = 3'h6;
  localparam logic [1:0] ROT_0 = 2'h0;
  localparam logic [1:0] ROT_90 = 2'h1;
  localparam logic [1:0] ROT_180 = 2'h2;
  localparam logic [1:0] ROT_270 = 2'h3;
  localparam logic [1:0] SIZE_NONE = 2'h0;
  localparam logic [1:0] SIZE_DOUBLE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
endpackage

// File: src/window_rotator.sv
// Window write-path coordinate rotation into display-buffer space
`timescale 1ns/100ps
module window_rotator #(
  parameter int CW = 10,
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Window geometry
  input wire logic [1:0] i_rot,
  input wire logic [CW-1:0] i_xs,
  input wire logic [CW-1:0] i_ys,
  input wire logic [CW-1:0] i_w,
  input wire logic [CW-1:0] i_h,
  input wire logic i_dbuf,
  // Host pixel in
  input wire logic i_valid,
  input wire logic [CW-1:0] i_col,
  input wire logic [CW-1:0] i_row,
  input wire logic [DW-1:0] i_data,
  // Buffer write out
  output logic o_valid,
  output logic [CW-1:0] o_x,
  output logic [CW-1:0] o_y,
  output logic [DW-1:0] o_data,
  output logic o_dbuf
);
  logic [CW-1:0] rx;
  logic [CW-1:0] ry;
  logic nxt_valid;
  logic [CW-1:0] nxt_x;
  logic [CW-1:0] nxt_y;
  logic [DW-1:0] nxt_data;
  logic nxt_dbuf;
  logic valid_ff;
  logic [CW-1:0] x_ff;
  logic [CW-1:0] y_ff;
  logic [DW-1:0] data_ff;
  logic dbuf_ff;

  // Rotation happens before storage, so each window keeps its own orientation
  always_comb begin
    unique case (i_rot)
      dmwe_pkg::ROT_0: begin
        rx = i_col;
        ry = i_row;
      end
      dmwe_pkg::ROT_90: begin
        rx = i_h - i_row;
        ry = i_col;
      end
      dmwe_pkg::ROT_180: begin
        rx = i_w - i_col;
        ry = i_h - i_row;
      end
      dmwe_pkg::ROT_270: begin
        rx = i_row;
        ry = i_w - i_col;
      end
    endcase
    nxt_valid = i_valid;
    nxt_x = i_valid ? i_xs + rx : x_ff;
    nxt_y = i_valid ? i_ys + ry : y_ff;
    nxt_data = i_valid ? i_data : data_ff;
    nxt_dbuf = i_valid ? i_dbuf : dbuf_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_ff <= 1'b0;
      x_ff <= '0;
      y_ff <= '0;
      data_ff <= '0;
      dbuf_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      data_ff <= nxt_data;
      dbuf_ff <= nxt_dbuf;
    end
  end

  assign o_valid = valid_ff;
  assign o_x = x_ff;
  assign o_y = y_ff;
  assign o_data = data_ff;
  assign o_dbuf = dbuf_ff;
endmodule // window_rotator

// File: src/display_mode_window_effects.sv
// Display-mode and window special-effects register bank with window and display paths
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module display_mode_window_effects #(
  parameter int CW = 10,
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Window definition from host
  input wire logic i_win_start,
  input wire logic [CW-1:0] i_win_xs,
  input wire logic [CW-1:0] i_win_ys,
  input wire logic [CW-1:0] i_win_xe,
  input wire logic [CW-1:0] i_win_ye,
  // Host pixel data
  input wire logic i_hw_valid,
  input wire logic [CW-1:0] i_hw_col,
  input wire logic [CW-1:0] i_hw_row,
  input wire logic [DW-1:0] i_hw_data,
  // Buffer write
  output logic o_bw_valid,
  output logic [CW-1:0] o_bw_x,
  output logic [CW-1:0] o_bw_y,
  output logic [DW-1:0] o_bw_data,
  output logic o_bw_dbuf,
  // Latched window state, plus the unlatched double-buffer enable, for the display pipe
  output logic o_win_size_dbl,
  output logic o_win_size_half,
  output logic [CW-1:0] o_win_xe_eff,
  output logic [CW-1:0] o_win_ye_eff,
  output logic o_db_enable,
  output logic o_db_win_valid,
  output logic [CW-1:0] o_db_xs,
  output logic [CW-1:0] o_db_ys,
  output logic [CW-1:0] o_db_xe,
  output logic [CW-1:0] o_db_ye,
  output logic o_dbl_valid,
  // Display pipe
  input wire logic i_dp_valid,
  input wire logic [DW-1:0] i_dp_pix,
  input wire logic [DW-1:0] i_dp_above,
  input wire logic i_dp_interp_h,
  input wire logic i_dp_interp_v,
  output logic o_dp_valid,
  output logic [DW-1:0] o_dp_pix,
  output logic o_temporal_shading,
  output logic o_dither
);
  localparam int NCH = DW / 8;

  // ********************************
  // Register bank
  // ********************************
  logic [7:0] mode_ff;
  logic [7:0] fx_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_mode;
  logic [7:0] nxt_fx;
  logic [7:0] nxt_rdata;
  logic [7:0] status;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_fx = fx_ff;
    if (i_wr && i_addr == dmwe_pkg::OFS_DISP_MODE) begin
      nxt_mode = i_wdata;
      nxt_mode[2] = 1'b0;
    end
    if (i_wr && i_addr == dmwe_pkg::OFS_WIN_FX) begin
      nxt_fx = i_wdata & 8'hc3;
    end
    nxt_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        dmwe_pkg::OFS_DISP_MODE: nxt_rdata = mode_ff;
        dmwe_pkg::OFS_WIN_FX: nxt_rdata = fx_ff;
        dmwe_pkg::OFS_STATUS: nxt_rdata = status;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff <= dmwe_pkg::RST_DISP_MODE;
      fx_ff <= dmwe_pkg::RST_WIN_FX;
      rdata_ff <= 8'h00;
    end else begin
      mode_ff <= nxt_mode;
      fx_ff <= nxt_fx;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  logic blank;
  logic [2:0] shade;
  logic [1:0] rot;
  logic dtype;
  logic dben;
  logic [1:0] sizing;
  assign blank = mode_ff[dmwe_pkg::BIT_BLANK];
  assign shade = mode_ff[dmwe_pkg::SHADE_LSB +: 3];
  assign rot = mode_ff[dmwe_pkg::ROT_LSB +: 2];
  assign dtype = fx_ff[dmwe_pkg::BIT_DTYPE];
  assign dben = fx_ff[dmwe_pkg::BIT_DBEN];
  assign sizing = fx_ff[dmwe_pkg::SIZE_LSB +: 2];

  // Reserved shading codes fall back to bypass
  assign o_temporal_shading = (shade == dmwe_pkg::SHADE_TEMPORAL) ||
                              (shade == dmwe_pkg::SHADE_BOTH);
  assign o_dither = (shade == dmwe_pkg::SHADE_DITHER) ||
                    (shade == dmwe_pkg::SHADE_BOTH);
  assign o_db_enable = dben;

  // ********************************
  // Window latch at start of window
  // ********************************
  logic [1:0] wrot_ff;
  logic wdbuf_ff;
  logic [1:0] wsize_ff;
  logic [CW-1:0] wxs_ff;
  logic [CW-1:0] wys_ff;
  logic [CW-1:0] ww_ff;
  logic [CW-1:0] wh_ff;
  logic [CW-1:0] xe_eff_ff;
  logic [CW-1:0] ye_eff_ff;
  logic dbv_ff;
  logic [CW-1:0] dbxs_ff;
  logic [CW-1:0] dbys_ff;
  logic [CW-1:0] dbxe_ff;
  logic [CW-1:0] dbye_ff;
  logic dblv_ff;
  logic [CW-1:0] dlxs_ff;
  logic [CW-1:0] dlys_ff;
  logic [CW-1:0] dlxe_ff;
  logic [CW-1:0] dlye_ff;
  logic [1:0] nxt_wrot;
  logic nxt_wdbuf;
  logic [1:0] nxt_wsize;
  logic [CW-1:0] nxt_wxs;
  logic [CW-1:0] nxt_wys;
  logic [CW-1:0] nxt_ww;
  logic [CW-1:0] nxt_wh;
  logic [CW-1:0] nxt_xe_eff;
  logic [CW-1:0] nxt_ye_eff;
  logic nxt_dbv;
  logic [CW-1:0] nxt_dbxs;
  logic [CW-1:0] nxt_dbys;
  logic [CW-1:0] nxt_dbxe;
  logic [CW-1:0] nxt_dbye;
  logic nxt_dblv;
  logic [CW-1:0] nxt_dlxs;
  logic [CW-1:0] nxt_dlys;
  logic [CW-1:0] nxt_dlxe;
  logic [CW-1:0] nxt_dlye;
  logic [CW-1:0] dx;
  logic [CW-1:0] dy;
  logic overlap;

  always_comb begin
    dx = i_win_xe - i_win_xs;
    dy = i_win_ye - i_win_ys;
    overlap = (i_win_xs <= dlxe_ff) && (i_win_xe >= dlxs_ff) &&
              (i_win_ys <= dlye_ff) && (i_win_ye >= dlys_ff);
    nxt_wrot = wrot_ff;
    nxt_wdbuf = wdbuf_ff;
    nxt_wsize = wsize_ff;
    nxt_wxs = wxs_ff;
    nxt_wys = wys_ff;
    nxt_ww = ww_ff;
    nxt_wh = wh_ff;
    nxt_xe_eff = xe_eff_ff;
    nxt_ye_eff = ye_eff_ff;
    nxt_dbv = dbv_ff;
    nxt_dbxs = dbxs_ff;
    nxt_dbys = dbys_ff;
    nxt_dbxe = dbxe_ff;
    nxt_dbye = dbye_ff;
    nxt_dblv = dblv_ff;
    nxt_dlxs = dlxs_ff;
    nxt_dlys = dlys_ff;
    nxt_dlxe = dlxe_ff;
    nxt_dlye = dlye_ff;
    if (i_win_start) begin
      // Settings are taken here, so they must be in place before the window starts
      nxt_wrot = rot;
      nxt_wdbuf = dtype && dben;
      nxt_wsize = sizing;
      nxt_wxs = i_win_xs;
      nxt_wys = i_win_ys;
      nxt_ww = dx;
      nxt_wh = dy;
      // Start corner stays put whatever the sizing
      unique case (sizing)
        dmwe_pkg::SIZE_DOUBLE: begin
          nxt_xe_eff = i_win_xs + {dx[CW-2:0], 1'b1};
          nxt_ye_eff = i_win_ys + {dy[CW-2:0], 1'b1};
        end
        dmwe_pkg::SIZE_HALF: begin
          nxt_xe_eff = i_win_xs + (dx >> 1);
          nxt_ye_eff = i_win_ys + (dy >> 1);
        end
        default: begin
          nxt_xe_eff = i_win_xe;
          nxt_ye_eff = i_win_ye;
        end
      endcase
      // A new buffered window replaces the old one; type zero leaves it guarded
      if (dtype && dben) begin
        nxt_dbv = 1'b1;
        nxt_dbxs = i_win_xs;
        nxt_dbys = i_win_ys;
        nxt_dbxe = i_win_xe;
        nxt_dbye = i_win_ye;
      end
      // One doubled window at most: a new one takes over, an overlap cancels
      if (sizing == dmwe_pkg::SIZE_DOUBLE) begin
        nxt_dblv = 1'b1;
        nxt_dlxs = i_win_xs;
        nxt_dlys = i_win_ys;
        nxt_dlxe = i_win_xs + {dx[CW-2:0], 1'b1};
        nxt_dlye = i_win_ys + {dy[CW-2:0], 1'b1};
      end else if (overlap) begin
        nxt_dblv = 1'b0;
      end
    end
    if (!dben) begin
      nxt_dbv = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wrot_ff <= dmwe_pkg::ROT_0;
      wdbuf_ff <= 1'b0;
      wsize_ff <= dmwe_pkg::SIZE_NONE;
      wxs_ff <= '0;
      wys_ff <= '0;
      ww_ff <= '0;
      wh_ff <= '0;
      xe_eff_ff <= '0;
      ye_eff_ff <= '0;
      dbv_ff <= 1'b0;
      dbxs_ff <= '0;
      dbys_ff <= '0;
      dbxe_ff <= '0;
      dbye_ff <= '0;
      dblv_ff <= 1'b0;
      dlxs_ff <= '0;
      dlys_ff <= '0;
      dlxe_ff <= '0;
      dlye_ff <= '0;
    end else begin
      wrot_ff <= nxt_wrot;
      wdbuf_ff <= nxt_wdbuf;
      wsize_ff <= nxt_wsize;
      wxs_ff <= nxt_wxs;
      wys_ff <= nxt_wys;
      ww_ff <= nxt_ww;
      wh_ff <= nxt_wh;
      xe_eff_ff <= nxt_xe_eff;
      ye_eff_ff <= nxt_ye_eff;
      dbv_ff <= nxt_dbv;
      dbxs_ff <= nxt_dbxs;
      dbys_ff <= nxt_dbys;
      dbxe_ff <= nxt_dbxe;
      dbye_ff <= nxt_dbye;
      dblv_ff <= nxt_dblv;
      dlxs_ff <= nxt_dlxs;
      dlys_ff <= nxt_dlys;
      dlxe_ff <= nxt_dlxe;
      dlye_ff <= nxt_dlye;
    end
  end

  assign o_win_size_dbl = (wsize_ff == dmwe_pkg::SIZE_DOUBLE);
  assign o_win_size_half = (wsize_ff == dmwe_pkg::SIZE_HALF);
  assign o_win_xe_eff = xe_eff_ff;
  assign o_win_ye_eff = ye_eff_ff;
  assign o_db_win_valid = dbv_ff;
  assign o_db_xs = dbxs_ff;
  assign o_db_ys = dbys_ff;
  assign o_db_xe = dbxe_ff;
  assign o_db_ye = dbye_ff;
  assign o_dbl_valid = dblv_ff;
  assign status = {5'h00, wdbuf_ff, dblv_ff, dbv_ff};

  window_rotator #(.CW(CW), .DW(DW)) u_rot (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_rot(wrot_ff),
    .i_xs(wxs_ff),
    .i_ys(wys_ff),
    .i_w(ww_ff),
    .i_h(wh_ff),
    .i_dbuf(wdbuf_ff),
    .i_valid(i_hw_valid),
    .i_col(i_hw_col),
    .i_row(i_hw_row),
    .i_data(i_hw_data),
    .o_valid(o_bw_valid),
    .o_x(o_bw_x),
    .o_y(o_bw_y),
    .o_data(o_bw_data),
    .o_dbuf(o_bw_dbuf)
  );

  // ********************************
  // Display output with doubling filter
  // ********************************
  logic [DW-1:0] prev_ff;
  logic [DW-1:0] dpix_ff;
  logic dval_ff;
  logic [DW-1:0] havg;
  logic [DW-1:0] vavg;
  logic [DW-1:0] nxt_prev;
  logic [DW-1:0] nxt_dpix;
  logic nxt_dval;

  // Per-channel averaging avoids blocky replication
  for (genvar c = 0; c < NCH; c++) begin : g_avg
    logic [8:0] hs;
    logic [7:0] hsel;
    logic [8:0] vs;
    assign hs = {1'b0, i_dp_pix[8*c +: 8]} + {1'b0, prev_ff[8*c +: 8]};
    assign hsel = i_dp_interp_h ? hs[8:1] : i_dp_pix[8*c +: 8];
    assign vs = {1'b0, hsel} + {1'b0, i_dp_above[8*c +: 8]};
    assign havg[8*c +: 8] = hsel;
    assign vavg[8*c +: 8] = vs[8:1];
  end

  always_comb begin
    nxt_prev = i_dp_valid ? i_dp_pix : prev_ff;
    nxt_dval = i_dp_valid;
    nxt_dpix = dpix_ff;
    if (i_dp_valid) begin
      nxt_dpix = i_dp_interp_v ? vavg : havg;
    end
    if (blank) begin
      nxt_dpix = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_ff <= '0;
      dpix_ff <= '0;
      dval_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      dpix_ff <= nxt_dpix;
      dval_ff <= nxt_dval;
    end
  end

  assign o_dp_valid = dval_ff;
  assign o_dp_pix = dpix_ff;

  // ********************************
  // Assertions
  // ********************************
  property p_blank;
    @(posedge i_clk) disable iff (!i_rst_b) blank |=> (o_dp_pix == '0);
  endproperty
  a_blank: assert property (p_blank) else $error("pixel not zero while blanked");

  property p_rsv;
    @(posedge i_clk) disable iff (!i_rst_b)
      !(i_wr && i_addr == dmwe_pkg::OFS_DISP_MODE) |=> $stable(mode_ff[dmwe_pkg::BIT_RSV]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit changed without a write");

  // Catches a wrong reset value, which the stability check above cannot see
  property p_rsv_rst;
    @(posedge i_clk) disable iff (!i_rst_b)
      $rose(i_rst_b) |-> mode_ff[dmwe_pkg::BIT_RSV];
  endproperty
  a_rsv_rst: assert property (p_rsv_rst) else $error("reserved bit not one after reset");

  property p_shade;
    @(posedge i_clk) disable iff (!i_rst_b)
      (o_temporal_shading == (shade == 3'h1 || shade == 3'h6)) &&
      (o_dither == (shade == 3'h4 || shade == 3'h6));
  endproperty
  a_shade: assert property (p_shade) else $error("shading decode wrong");

  property p_rot0;
    @(posedge i_clk) disable iff (!i_rst_b)
      (i_hw_valid && wrot_ff == 2'h0) |=> (o_bw_x == $past(wxs_ff) + $past(i_hw_col)) &&
        (o_bw_y == $past(wys_ff) + $past(i_hw_row));
  endproperty
  a_rot0: assert property (p_rot0) else $error("unrotated write address wrong");

  property p_rot180;
    @(posedge i_clk) disable iff (!i_rst_b)
      (i_hw_valid && wrot_ff == 2'h2) |=>
        (o_bw_x == $past(wxs_ff) + $past(ww_ff) - $past(i_hw_col));
  endproperty
  a_rot180: assert property (p_rot180) else $error("half-turn write address wrong");

  property p_dbuf;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_win_start ##1 !i_win_start ##1 (i_hw_valid && !i_win_start) |=>
        (o_bw_dbuf == ($past(dtype, 3) && $past(dben, 3)));
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("buffer selection of write wrong");

  property p_keep_db;
    @(posedge i_clk) disable iff (!i_rst_b)
      (dbv_ff && dben && !dtype && i_win_start) |=> dbv_ff && $stable(dbxs_ff);
  endproperty
  a_keep_db: assert property (p_keep_db) else $error("guarded window lost");

  property p_db_off;
    @(posedge i_clk) disable iff (!i_rst_b) !dben |=> !o_db_win_valid;
  endproperty
  a_db_off: assert property (p_db_off) else $error("buffered window kept while disabled");

  property p_dbl;
    @(posedge i_clk) disable iff (!i_rst_b)
      (i_win_start && sizing == 2'h1) |=> o_dbl_valid && o_win_size_dbl &&
        (dlxs_ff == $past(i_win_xs)) && (dlys_ff == $past(i_win_ys));
  endproperty
  a_dbl: assert property (p_dbl) else $error("doubled window not anchored");

  property p_half;
    @(posedge i_clk) disable iff (!i_rst_b)
      (i_win_start && sizing == 2'h2) |=>
        (o_win_xe_eff == $past(i_win_xs) + (($past(i_win_xe) - $past(i_win_xs)) >> 1));
  endproperty
  a_half: assert property (p_half) else $error("halved extent wrong");

  property p_havg;
    @(posedge i_clk) disable iff (!i_rst_b)
      (i_dp_valid && i_dp_interp_h && !i_dp_interp_v && !blank) |=>
        (o_dp_pix[7:0] == 8'((9'($past(i_dp_pix[7:0])) + 9'($past(prev_ff[7:0]))) >> 1));
  endproperty
  a_havg: assert property (p_havg) else $error("horizontal average wrong");

  c_blank: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(blank));
  c_dbwin: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_db_win_valid));
  c_dbl: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_dbl_valid ##1 !o_dbl_valid);
endmodule // display_mode_window_effects

// File: bench/host_model.sv
// Host model that defines windows and streams pixel data into the write path
`timescale 1ns/100ps
module host_model #(
  parameter int CW = 10,
  parameter int DW = 24
) (
  // Clock
  input wire logic i_clk,
  // Window definition
  output logic o_win_start,
  output logic [CW-1:0] o_xs,
  output logic [CW-1:0] o_ys,
  output logic [CW-1:0] o_xe,
  output logic [CW-1:0] o_ye,
  // Pixel data
  output logic o_hw_valid,
  output logic [CW-1:0] o_col,
  output logic [CW-1:0] o_row,
  output logic [DW-1:0] o_data
);
  initial begin
    o_win_start = 1'b0;
    o_xs = '0;
    o_ys = '0;
    o_xe = '0;
    o_ye = '0;
    o_hw_valid = 1'b0;
    o_col = '0;
    o_row = '0;
    o_data = '0;
  end
  // Caller writes the effect registers first; coordinates stay put afterwards
  // Overlapping a doubled window is how doubling gets cancelled
  task automatic send_window(input logic [CW-1:0] xs, ys, xe, ye);
    @(posedge i_clk);
    o_win_start <= 1'b1;
    o_xs <= xs;
    o_ys <= ys;
    o_xe <= xe;
    o_ye <= ye;
    @(posedge i_clk);
    o_win_start <= 1'b0;
  endtask
  task automatic send_pixel(input logic [CW-1:0] col, row, input logic [DW-1:0] d);
    @(posedge i_clk);
    o_hw_valid <= 1'b1;
    o_col <= col;
    o_row <= row;
    o_data <= d;
    @(posedge i_clk);
    o_hw_valid <= 1'b0;
    // Idle data lines carry junk so stale values never look valid
    o_data <= ~d;
    #1;
  endtask
endmodule // host_model

// File: bench/display_mode_window_effects_bench.sv
// Self-checking bench for the display-mode and window-effects bank
`timescale 1ns/100ps
module display_mode_window_effects_bench;
  logic i_clk, i_rst_b, i_wr, i_rd, i_dp_valid, i_dp_interp_h, i_dp_interp_v;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [23:0] i_dp_pix, i_dp_above, o_dp_pix, o_bw_data, hw_data;
  logic win_start, hw_valid, o_bw_valid, o_bw_dbuf, o_win_size_dbl, o_win_size_half;
  logic o_db_enable, o_db_win_valid, o_dbl_valid, o_dp_valid, o_temporal_shading, o_dither;
  logic [9:0] win_xs, win_ys, win_xe, win_ye, hw_col, hw_row, o_bw_x, o_bw_y;
  logic [9:0] o_win_xe_eff, o_win_ye_eff, o_db_xs, o_db_xe;
  logic [31:0] seed = 32'h3830ed8e;
  int bad_count = 0;
  int samples_checked = 0;

  display_mode_window_effects u_display_mode_window_effects (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_win_start(win_start), .i_win_xs(win_xs),
    .i_win_ys(win_ys), .i_win_xe(win_xe), .i_win_ye(win_ye), .i_hw_valid(hw_valid),
    .i_hw_col(hw_col), .i_hw_row(hw_row), .i_hw_data(hw_data), .o_bw_valid(o_bw_valid),
    .o_bw_x(o_bw_x), .o_bw_y(o_bw_y), .o_bw_data(o_bw_data), .o_bw_dbuf(o_bw_dbuf),
    .o_win_size_dbl(o_win_size_dbl), .o_win_size_half(o_win_size_half),
    .o_win_xe_eff(o_win_xe_eff), .o_win_ye_eff(o_win_ye_eff), .o_db_enable(o_db_enable),
    .o_db_win_valid(o_db_win_valid), .o_db_xs(o_db_xs), .o_db_ys(), .o_db_xe(o_db_xe),
    .o_db_ye(), .o_dbl_valid(o_dbl_valid), .i_dp_valid(i_dp_valid), .i_dp_pix(i_dp_pix),
    .i_dp_above(i_dp_above), .i_dp_interp_h(i_dp_interp_h), .i_dp_interp_v(i_dp_interp_v),
    .o_dp_valid(o_dp_valid), .o_dp_pix(o_dp_pix), .o_temporal_shading(o_temporal_shading),
    .o_dither(o_dither));

  host_model u_host_model (
    .i_clk(i_clk), .o_win_start(win_start), .o_xs(win_xs), .o_ys(win_ys), .o_xe(win_xe),
    .o_ye(win_ye), .o_hw_valid(hw_valid), .o_col(hw_col), .o_row(hw_row), .o_data(hw_data));

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [23:0] avg(input logic [23:0] a, b);
    logic [8:0] s;
    logic [23:0] r;
    for (int i = 0; i < 3; i++) begin
      s = {1'b0, a[8*i+:8]} + {1'b0, b[8*i+:8]};
      r[8*i+:8] = s[8:1];
    end
    return r;
  endfunction
  // Window 10,20..13,21 with pixel at col 2 row 1
  function automatic logic [19:0] rot_exp(input int r);
    case (r)
      0: return {10'd12, 10'd21};
      1: return {10'd10, 10'd22};
      2: return {10'd11, 10'd20};
      default: return {10'd11, 10'd21};
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd_chk(input logic [7:0] a, exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp);
  endtask
  task automatic dp(input logic [23:0] pix, above, input logic h, v);
    @(posedge i_clk);
    i_dp_valid <= 1'b1;
    i_dp_pix <= pix;
    i_dp_above <= above;
    i_dp_interp_h <= h;
    i_dp_interp_v <= v;
    @(posedge i_clk);
    i_dp_valid <= 1'b0;
    i_dp_pix <= ~pix;
    #1;
    check(o_dp_valid, 1'b1);
  endtask
  task automatic fx_win(input logic [7:0] fx, input logic [9:0] xs);
    reg_wr(dmwe_pkg::OFS_WIN_FX, fx);
    u_host_model.send_window(xs, 10'd20, xs + 10'd3, 10'd21);
    seed = lfsr(seed);
    u_host_model.send_pixel(10'd0, 10'd0, seed[23:0]);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********************************
  // Clock, watchdog and tests
  // ********************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [23:0] p, q, a;
    i_rst_b = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_dp_valid = 1'b0;
    i_dp_pix = 24'h0;
    i_dp_above = 24'h0;
    i_dp_interp_h = 1'b0;
    i_dp_interp_v = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    reg_rd_chk(dmwe_pkg::OFS_DISP_MODE, dmwe_pkg::RST_DISP_MODE);
    reg_rd_chk(dmwe_pkg::OFS_WIN_FX, dmwe_pkg::RST_WIN_FX);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      reg_wr(dmwe_pkg::OFS_DISP_MODE, seed[7:0]);
      reg_wr(8'h35, ~seed[7:0]);
      reg_rd_chk(dmwe_pkg::OFS_DISP_MODE, seed[7:0] & 8'hfb);
      reg_wr(dmwe_pkg::OFS_WIN_FX, seed[15:8]);
      reg_rd_chk(dmwe_pkg::OFS_WIN_FX, seed[15:8] & 8'hc3);
    end
    reg_rd_chk(8'h51, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      reg_wr(dmwe_pkg::OFS_DISP_MODE, {1'b0, k[2:0], 4'h8});
      check(o_temporal_shading, k == 1 || k == 6);
      check(o_dither, k == 4 || k == 6);
    end
    for (int k = 0; k < 2; k++) begin
      reg_wr(dmwe_pkg::OFS_DISP_MODE, {k[0], 7'h08});
      seed = lfsr(seed);
      dp(seed[23:0], 24'h0, 1'b0, 1'b0);
      check(o_dp_pix, k[0] ? 24'h0 : seed[23:0]);
    end
    $display("test display mode done");
    for (int k = 0; k < 4; k++) begin
      reg_wr(dmwe_pkg::OFS_DISP_MODE, {6'h02, k[1:0]});
      u_host_model.send_window(10'd10, 10'd20, 10'd13, 10'd21);
      seed = lfsr(seed);
      u_host_model.send_pixel(10'd2, 10'd1, seed[23:0]);
      check(o_bw_valid, 1'b1);
      check({o_bw_x, o_bw_y}, rot_exp(k));
      check(o_bw_data, seed[23:0]);
    end
    $display("test rotation done");
    reg_wr(dmwe_pkg::OFS_DISP_MODE, 8'h08);
    fx_win(8'hc0, 10'd40);
    check(o_bw_dbuf, 1'b1);
    check(o_db_enable, 1'b1);
    check({o_db_win_valid, o_db_xs, o_db_xe}, {1'b1, 10'd40, 10'd43});
    fx_win(8'h40, 10'd100);
    check(o_bw_dbuf, 1'b0);
    check({o_db_win_valid, o_db_xs}, {1'b1, 10'd40});
    fx_win(8'h80, 10'd200);
    check(o_bw_dbuf, 1'b0);
    check({o_db_enable, o_db_win_valid}, 2'b00);
    $display("test double buffer done");
    fx_win(8'h01, 10'd10);
    check({o_win_size_dbl, o_win_size_half, o_dbl_valid}, 3'b101);
    check({o_win_xe_eff, o_win_ye_eff}, {10'd17, 10'd23});
    reg_rd_chk(dmwe_pkg::OFS_STATUS, 8'h02);
    seed = lfsr(seed);
    p = seed[23:0];
    seed = lfsr(seed);
    q = seed[23:0];
    a = ~seed[31:8];
    dp(q, a, 1'b0, 1'b0);
    dp(p, a, 1'b1, 1'b1);
    check(o_dp_pix, avg(avg(p, q), a));
    dp(q, a, 1'b1, 1'b0);
    check(o_dp_pix, avg(p, q));
    fx_win(8'h02, 10'd10);
    check({o_win_size_dbl, o_win_size_half, o_dbl_valid}, 3'b010);
    check({o_win_xe_eff, o_win_ye_eff}, {10'd11, 10'd20});
    fx_win(8'h03, 10'd10);
    check({o_win_size_dbl, o_win_size_half}, 2'b00);
    $display("test sizing done");
    tally_and_finish();
  end
endmodule // display_mode_window_effects_bench
